// [pkg/pgfs_pkg.sv]
// Constants, offsets and types shared by the power group fault sequencer
package pgfs_pkg;

	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	localparam int PGFS_NGRP = 4;
	localparam int PGFS_AW = 8;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PGFS_OFF_CTRL = 8'h00;
	localparam logic [7:0] PGFS_OFF_INTCFG = 8'h04;
	localparam logic [7:0] PGFS_OFF_INHMAP = 8'h08;
	localparam logic [7:0] PGFS_OFF_PROPMAP = 8'h0C;
	localparam logic [7:0] PGFS_OFF_MARGIN = 8'h10;
	localparam logic [7:0] PGFS_OFF_CMD = 8'h14;
	localparam logic [7:0] PGFS_OFF_STATUS = 8'h18;
	localparam logic [7:0] PGFS_OFF_PROGSTAT = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PGFS_CTRL_AUTO = 0;
	localparam int PGFS_CTRL_CROW = 1;
	localparam int PGFS_CTRL_FEOFF = 2;
	localparam int PGFS_CMD_ON = 0;
	localparam int PGFS_CMD_OFF = 4;
	localparam int PGFS_ST_ON = 0;
	localparam int PGFS_ST_DRV = 4;
	localparam int PGFS_ST_GOOD = 8;
	localparam int PGFS_ST_INT = 12;
	localparam int PGFS_ST_ML = 16;
	localparam int PGFS_ST_SD = 17;
	localparam int PGFS_ST_BUSY = 18;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PGFS_MRG_UP = 2'h1;
	localparam logic [1:0] PGFS_MRG_DN = 2'h2;
	localparam logic PGFS_RST_AUTO = 1'h0;
	localparam logic PGFS_RST_PIN = 1'h1;
	localparam logic [31:0] PGFS_RD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int PGFS_CLK_NS = 10;
	localparam int PGFS_INH_MAX_NS = 10000;
	localparam int PGFS_INH_MAX_CYC = PGFS_INH_MAX_NS / PGFS_CLK_NS;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic {
		PGFS_SQ_IDLE = 1'b0,
		PGFS_SQ_PROG = 1'b1
	} pgfs_sq_t;

endpackage

// [hw/pgfs_sync.sv]
// Two-stage synchronizer for the active-low control inputs
`timescale 1ns/100ps
module pgfs_sync
	import pgfs_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous in, synchronous out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pgfs_sync_st_t;

	pgfs_sync_st_t st_q;
	pgfs_sync_st_t st_d;

	always_comb begin
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	// Idle level of every input is high, so reset to released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= {(2 * W){PGFS_RST_PIN}};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;

endmodule

// [hw/pgfs_top.sv]
// Group good-line, interrupt and mains-loss sequencing with an APB register file
//
// Functional notes
// - Low good line propagates to programmed other groups.
// - Propagated error may kill front end, crowbar.
// - Margin per group, direction set per group.
// - Host on/off per group; auto on at power-up.
// - Four interrupts, each inhibit or reprogram trigger.
// - Low inhibit holds all its assigned groups low.
// - Inhibit release frees lines; converters ramp on.
// - Inhibit pulls lines low within ten microseconds.
// - Reprogram trigger i maps fixed to group i.
// - Trigger low programs group, then auto-on.
// - Trigger release pulls group low, clears status.
// - Mains loss or shutdown pulls all groups low.
// - Assertion clears status, saves counter, flags input.
// - Release programs all, then auto-on or wait.
// - Shutdown input behaves like mains loss; only its status bit differs.
`timescale 1ns/100ps
module pgfs_top
	import pgfs_pkg::*;
#(
	parameter int NGRP = PGFS_NGRP
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PGFS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Open-drain group good lines
	input wire logic [NGRP-1:0] good_in,
	output logic [NGRP-1:0] good_out,
	output logic [NGRP-1:0] good_oe_n,
	// Active-low control inputs
	input wire logic [NGRP-1:0] interrupt_input_n,
	input wire logic mains_loss_input_n,
	input wire logic system_shutdown_input_n,
	// Converter programming engine handshake
	output logic [NGRP-1:0] prog_req,
	input wire logic prog_done,
	// Margining per group
	output logic [NGRP-1:0] margin_up,
	output logic [NGRP-1:0] margin_dn,
	// Front end and housekeeping
	output logic front_end_off,
	output logic crowbar,
	output logic rtc_save
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pgfs_sq_t sq;
		logic auto_en;
		logic crow_en;
		logic fe_en;
		logic [NGRP-1:0] int_mode;
		logic [NGRP*NGRP-1:0] inh_map;
		logic [NGRP*NGRP-1:0] prop_map;
		logic [2*NGRP-1:0] margin;
		logic [NGRP-1:0] group_on;
		logic [NGRP-1:0] prog_stat;
		logic [NGRP-1:0] prog_pend;
		logic [NGRP-1:0] prog_req;
		logic [NGRP-1:0] int_prev;
		logic [NGRP-1:0] drive;
		logic [NGRP-1:0] good_lvl;
		logic [NGRP-1:0] oe_n;
		logic [NGRP-1:0] mrg_up;
		logic [NGRP-1:0] mrg_dn;
		logic ml_prev;
		logic sd_prev;
		logic rtc_save;
		logic crowbar;
		logic fe_off;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pgfs_st_t;

	// Power-up: every group pending programming, every line held low
	localparam pgfs_st_t ST_RST = '{
		sq: PGFS_SQ_IDLE,
		auto_en: PGFS_RST_AUTO,
		crow_en: 1'b0,
		fe_en: 1'b0,
		int_mode: '0,
		inh_map: '0,
		prop_map: '0,
		margin: '0,
		group_on: '0,
		prog_stat: '0,
		prog_pend: {NGRP{1'b1}},
		prog_req: '0,
		int_prev: {NGRP{PGFS_RST_PIN}},
		drive: {NGRP{1'b1}},
		good_lvl: '0,
		oe_n: '0,
		mrg_up: '0,
		mrg_dn: '0,
		ml_prev: PGFS_RST_PIN,
		sd_prev: PGFS_RST_PIN,
		rtc_save: 1'b0,
		crowbar: 1'b0,
		fe_off: 1'b0,
		prdata: PGFS_RD_ZERO,
		pready: 1'b0,
		pslverr: 1'b0
	};

	pgfs_st_t st_q;
	pgfs_st_t st_d;

	// ----------------------------------------------------------------
	// Input synchronizers
	// ----------------------------------------------------------------
	logic [NGRP-1:0] int_s;
	logic ml_s;
	logic sd_s;

	// One chain for all control pins, all resetting to the released level
	pgfs_sync #(.W(NGRP + 2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({interrupt_input_n, mains_loss_input_n, system_shutdown_input_n}),
		.sync_out({int_s, ml_s, sd_s})
	);

	// ----------------------------------------------------------------
	// Per-group terms
	// ----------------------------------------------------------------
	logic [NGRP-1:0] src;
	logic [NGRP-1:0] prop_hit;
	logic [NGRP-1:0] inh_hit;
	logic [NGRP-1:0] mrg_up_w;
	logic [NGRP-1:0] mrg_dn_w;
	logic [NGRP-1:0] prop_col [NGRP];
	logic [NGRP-1:0] inh_col [NGRP];

	genvar g, s;
	generate
		for (g = 0; g < NGRP; g++) begin : g_grp
			// Low line not pulled by us is a converter fault in that group
			assign src[g] = ~good_in[g] & ~st_q.drive[g];
			// A group never feeds itself; only inhibit-mode interrupts hold lines
			for (s = 0; s < NGRP; s++) begin : g_src
				assign prop_col[g][s] = (s != g) & st_q.prop_map[s * NGRP + g];
				assign inh_col[g][s] = ~st_q.int_mode[s] & st_q.inh_map[s * NGRP + g];
			end
			assign prop_hit[g] = |(src & prop_col[g]);
			assign inh_hit[g] = |(inh_col[g] & ~int_s);
			assign mrg_up_w[g] = st_q.margin[2 * g +: 2] == PGFS_MRG_UP;
			assign mrg_dn_w[g] = st_q.margin[2 * g +: 2] == PGFS_MRG_DN;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic setup;
	logic wr;
	logic kill;
	logic ml_fall;
	logic sd_fall;
	logic any_rise;
	logic [NGRP-1:0] trig_fall;
	logic [NGRP-1:0] trig_rise;

	always_comb begin
		st_d = st_q;
		setup = psel & ~penable;
		wr = psel & penable & st_q.pready & pwrite & ~st_q.pslverr;
		kill = ~ml_s | ~sd_s;
		// Previous levels reset released, so reset makes no false edge
		ml_fall = st_q.ml_prev & ~ml_s;
		sd_fall = st_q.sd_prev & ~sd_s;
		any_rise = (~st_q.ml_prev & ml_s) | (~st_q.sd_prev & sd_s);
		trig_fall = st_q.int_mode & st_q.int_prev & ~int_s;
		trig_rise = st_q.int_mode & ~st_q.int_prev & int_s;
		st_d.int_prev = int_s;
		st_d.ml_prev = ml_s;
		st_d.sd_prev = sd_s;
		// Pulses and the bus answer last a single cycle
		st_d.rtc_save = 1'b0;
		st_d.pready = 1'b0;
		st_d.pslverr = 1'b0;

		// ------------------------------------------------------------
		// APB read decode
		// ------------------------------------------------------------
		// APB: decode in setup, answer in the single access cycle
		if (setup) begin
			st_d.pready = 1'b1;
			st_d.prdata = PGFS_RD_ZERO;
			unique case (paddr)
				PGFS_OFF_CTRL: begin
					st_d.prdata[PGFS_CTRL_AUTO] = st_q.auto_en;
					st_d.prdata[PGFS_CTRL_CROW] = st_q.crow_en;
					st_d.prdata[PGFS_CTRL_FEOFF] = st_q.fe_en;
				end
				PGFS_OFF_INTCFG: st_d.prdata[NGRP-1:0] = st_q.int_mode;
				PGFS_OFF_INHMAP: st_d.prdata[NGRP*NGRP-1:0] = st_q.inh_map;
				PGFS_OFF_PROPMAP: st_d.prdata[NGRP*NGRP-1:0] = st_q.prop_map;
				PGFS_OFF_MARGIN: st_d.prdata[2*NGRP-1:0] = st_q.margin;
				PGFS_OFF_CMD: st_d.prdata = PGFS_RD_ZERO;
				PGFS_OFF_STATUS: begin
					st_d.prdata[PGFS_ST_ON +: NGRP] = st_q.group_on;
					st_d.prdata[PGFS_ST_DRV +: NGRP] = st_q.drive;
					st_d.prdata[PGFS_ST_GOOD +: NGRP] = good_in;
					st_d.prdata[PGFS_ST_INT +: NGRP] = int_s;
					st_d.prdata[PGFS_ST_ML] = ~ml_s;
					st_d.prdata[PGFS_ST_SD] = ~sd_s;
					st_d.prdata[PGFS_ST_BUSY] = st_q.sq == PGFS_SQ_PROG;
				end
				PGFS_OFF_PROGSTAT: st_d.prdata[NGRP-1:0] = st_q.prog_stat;
				default: st_d.pslverr = 1'b1;
			endcase
		end

		// ------------------------------------------------------------
		// APB write
		// ------------------------------------------------------------
		// Software writes come first so hardware events override them
		if (wr) begin
			unique case (paddr)
				PGFS_OFF_CTRL: begin
					st_d.auto_en = pwdata[PGFS_CTRL_AUTO];
					st_d.crow_en = pwdata[PGFS_CTRL_CROW];
					st_d.fe_en = pwdata[PGFS_CTRL_FEOFF];
				end
				// One mode bit per interrupt keeps the two uses exclusive
				PGFS_OFF_INTCFG: st_d.int_mode = pwdata[NGRP-1:0];
				PGFS_OFF_INHMAP: st_d.inh_map = pwdata[NGRP*NGRP-1:0];
				PGFS_OFF_PROPMAP: st_d.prop_map = pwdata[NGRP*NGRP-1:0];
				PGFS_OFF_MARGIN: st_d.margin = pwdata[2*NGRP-1:0];
				PGFS_OFF_CMD: begin
					st_d.group_on = (st_q.group_on | pwdata[PGFS_CMD_ON +: NGRP])
						& ~pwdata[PGFS_CMD_OFF +: NGRP];
				end
				// Status is read-only: writes are dropped without an error
				PGFS_OFF_STATUS: st_d.prdata = st_q.prdata;
				PGFS_OFF_PROGSTAT: st_d.prog_stat = st_q.prog_stat & ~pwdata[NGRP-1:0];
				default: st_d.prdata = st_q.prdata;
			endcase
		end

		// ------------------------------------------------------------
		// Mains loss, shutdown and triggers
		// ------------------------------------------------------------
		// Mains loss and shutdown share one treatment
		if (ml_fall || sd_fall) begin
			st_d.rtc_save = 1'b1;
			st_d.prog_stat = '0;
			st_d.group_on = '0;
		end
		if (any_rise) begin
			st_d.prog_pend = {NGRP{1'b1}};
		end

		// Reprogram triggers act on the group of the same index
		st_d.prog_pend = st_d.prog_pend | trig_fall;
		if (|trig_rise) begin
			st_d.group_on = st_d.group_on & ~trig_rise;
			st_d.prog_stat = '0;
		end

		// ------------------------------------------------------------
		// Programming sequencer
		// ------------------------------------------------------------
		// Programming sequencer; waits while the system is held off
		unique case (st_q.sq)
			PGFS_SQ_IDLE: begin
				if (|st_q.prog_pend && !kill) begin
					st_d.prog_req = st_q.prog_pend;
					st_d.prog_pend = (st_d.prog_pend & ~st_q.prog_pend) | trig_fall;
					st_d.sq = PGFS_SQ_PROG;
				end
			end
			PGFS_SQ_PROG: begin
				if (prog_done) begin
					st_d.prog_stat = st_d.prog_stat | st_q.prog_req;
					// A trigger released in the prog_done cycle keeps its group off
					if (st_q.auto_en && !kill) begin
						st_d.group_on = st_d.group_on | (st_q.prog_req & ~trig_rise);
					end
					st_d.prog_req = '0;
					st_d.sq = PGFS_SQ_IDLE;
				end
			end
		endcase

		// ------------------------------------------------------------
		// Line drive and housekeeping
		// ------------------------------------------------------------
		// Three cycles from pin to pull-down, far inside the inhibit budget
		st_d.drive = ~st_d.group_on | inh_hit | prop_hit | {NGRP{kill}};
		st_d.oe_n = ~st_d.drive;
		st_d.good_lvl = '0;
		st_d.crowbar = st_q.crow_en & (|prop_hit);
		st_d.fe_off = st_q.fe_en & (|prop_hit);
		st_d.mrg_up = mrg_up_w;
		st_d.mrg_dn = mrg_dn_w;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign good_out = st_q.good_lvl;
	assign good_oe_n = st_q.oe_n;
	assign prog_req = st_q.prog_req;
	assign margin_up = st_q.mrg_up;
	assign margin_dn = st_q.mrg_dn;
	assign front_end_off = st_q.fe_off;
	assign crowbar = st_q.crowbar;
	assign rtc_save = st_q.rtc_save;

endmodule

// [tb/pgfs_asserts.sv]
// Port checker for the power group fault sequencer
`timescale 1ns/100ps
module pgfs_asserts
	import pgfs_pkg::*;
#(
	parameter int NGRP = PGFS_NGRP
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PGFS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Lines and controls
	input wire logic [NGRP-1:0] good_oe_n,
	input wire logic [NGRP-1:0] interrupt_input_n,
	input wire logic mains_loss_input_n,
	input wire logic [NGRP-1:0] prog_req,
	input wire logic prog_done,
	input wire logic [NGRP-1:0] margin_up,
	input wire logic rtc_save
);
	logic wr;
	logic [NGRP-1:0] cfg_q, im, m1_q, m2_q, m3_q;
	logic [NGRP*NGRP-1:0] map_q;
	assign wr = psel && penable && pready && pwrite;
	always_comb begin
		im = '0;
		for (int i = 0; i < NGRP; i++) begin
			if (!interrupt_input_n[i] && !cfg_q[i]) begin
				im = im | map_q[i*NGRP+:NGRP];
			end
		end
	end
	// Shadow of config writes; the design stores them at the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cfg_q, map_q, m1_q, m2_q, m3_q} <= '0;
		end else begin
			if (wr && paddr == PGFS_OFF_INTCFG) begin
				cfg_q <= pwdata[NGRP-1:0];
			end
			if (wr && paddr == PGFS_OFF_INHMAP) begin
				map_q <= pwdata[NGRP*NGRP-1:0];
			end
			{m1_q, m2_q, m3_q} <= {im, m1_q, m2_q};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a one cycle answer");
	a_bad_addr: assert property (psel && !penable && paddr >= 8'h20 |=> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	a_inhibit_hold: assert property ((good_oe_n & im & m1_q & m2_q & m3_q) == '0)
		else $error("inhibited group not held low");
	a_trig_release: assert property ($rose(interrupt_input_n[1]) && cfg_q[1] |-> ##[1:5] !good_oe_n[1])
		else $error("trigger release did not pull group low");
	a_prog_done: assert property (prog_done && prog_req != '0 |=> prog_req == '0)
		else $error("programming request outlived done");
	a_mains_all: assert property ((!mains_loss_input_n) [*4] |-> good_oe_n == '0)
		else $error("mains loss left a line released");
	a_rtc_save: assert property ($fell(mains_loss_input_n) |-> ##[2:4] rtc_save)
		else $error("run time counter not saved");
	a_margin_up: assert property (wr && paddr == PGFS_OFF_MARGIN && pwdata[1:0] == PGFS_MRG_UP |-> ##2 margin_up[0])
		else $error("margin up not applied");
endmodule

bind pgfs_top pgfs_asserts #(.NGRP(NGRP)) i_pgfs_asserts (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .good_oe_n, .interrupt_input_n,
	.mains_loss_input_n, .prog_req, .prog_done, .margin_up, .rtc_save);

// [tb/pgfs_pol_model.sv]
// Converter side model: programming answers and fault pulls on the good lines
`timescale 1ns/100ps
module pgfs_pol_model
	import pgfs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Design side
	input wire logic [PGFS_NGRP-1:0] good_oe_n,
	input wire logic [PGFS_NGRP-1:0] prog_req,
	output logic prog_done,
	output logic [PGFS_NGRP-1:0] good_line,
	// Bench control
	input wire logic [PGFS_NGRP-1:0] fault_pull,
	input wire logic [7:0] delay
);
	logic [7:0] cnt_q;
	// Pulled-up wire, only sunk; converters follow it, ramps not modelled
	assign good_line = good_oe_n & ~fault_pull;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cnt_q, prog_done} <= '0;
		end else if (prog_req != '0 && !prog_done) begin
			cnt_q <= cnt_q + 8'h01;
			prog_done <= (cnt_q == delay);
		end else begin
			{cnt_q, prog_done} <= '0;
		end
	end
endmodule

// [tb/tb_pgfs_top.sv]
// Self-checking bench for the power group fault sequencer
`timescale 1ns/100ps
module tb_pgfs_top
	import pgfs_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, prog_done, ml_n, sd_n, pready, pslverr, err;
	logic fe_off, crowbar, rtc_save;
	logic [7:0] paddr, delay, v;
	logic [31:0] pwdata, prdata, rd, inh_map;
	logic [3:0] good_in, good_out, good_oe_n, int_n, prog_req, mup, mdn, fpull, m;
	int num_errors, checks, rtc_cnt;
	pgfs_top i_pgfs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .good_in, .good_out, .good_oe_n, .interrupt_input_n(int_n),
		.mains_loss_input_n(ml_n), .system_shutdown_input_n(sd_n), .prog_req, .prog_done,
		.margin_up(mup), .margin_dn(mdn), .front_end_off(fe_off), .crowbar, .rtc_save);
	pgfs_pol_model i_pgfs_pol_model (.pclk, .presetn, .good_oe_n, .prog_req, .prog_done,
		.good_line(good_in), .fault_pull(fpull), .delay);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) if (rtc_save === 1'b1) rtc_cnt <= rtc_cnt + 1;
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// Request held until the edge that samples pready high; answer taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_prog;
		for (int i = 0; i < 300 && prog_req !== 4'h0; i++) @(negedge pclk);
		step(2);
	endtask
	function automatic logic [7:0] mexp(input logic [7:0] c);
		for (int g = 0; g < 4; g++) begin
			mexp[g] = c[2*g+:2] == PGFS_MRG_UP;
			mexp[g+4] = c[2*g+:2] == PGFS_MRG_DN;
		end
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		complete_run();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fpull, num_errors, checks, rtc_cnt} = '0;
		{ml_n, sd_n, int_n} = '1;
		delay = 8'h1E;
		v = 8'($urandom(32'h61A47F9D));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, PGFS_OFF_CTRL, 32'h1);
		chk(32'(prog_req), 32'hF, "power-up programming");
		wait_prog;
		chk(32'(good_oe_n), 32'hF, "auto turn-on");
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000, "unmapped");
		apb(1'b0, PGFS_OFF_INTCFG, 32'h0);
		chk(rd, 32'h0, "interrupt config reset");
		$display("done power-up");
		repeat (3) begin
			m = 4'($urandom);
			apb(1'b1, PGFS_OFF_CMD, {24'h0, m, 4'hF});
			step(2);
			chk(32'(good_oe_n), {28'h0, ~m}, "off wins over on");
			apb(1'b0, PGFS_OFF_STATUS, 32'h0);
			chk(32'(rd[3:0]), {28'h0, ~m}, "group on status");
			apb(1'b1, PGFS_OFF_CMD, 32'hF);
			step(2);
			chk(32'(good_oe_n), 32'hF, "host turn-on");
		end
		for (int k = 0; k < 4; k++) begin
			v = k == 0 ? 8'h39 : 8'($urandom);
			apb(1'b1, PGFS_OFF_MARGIN, {24'h0, v});
			step(2);
			chk(32'({mdn, mup}), 32'(mexp(v)), "margin");
		end
		$display("done host commands and margins");
		// Each interrupt inhibits its own random group set
		for (int i = 0; i < 4; i++) begin
			inh_map = $urandom;
			apb(1'b1, PGFS_OFF_INHMAP, inh_map);
			@(posedge pclk);
			int_n[i] <= 1'b0;
			step(3);
			chk(32'(good_oe_n), {28'h0, ~inh_map[i*4+:4]}, "inhibit holds");
			@(posedge pclk);
			int_n[i] <= 1'b1;
			step(3);
			chk(32'(good_oe_n), 32'hF, "inhibit release");
		end
		$display("done inhibit");
		apb(1'b1, PGFS_OFF_PROPMAP, 32'h6);
		apb(1'b1, PGFS_OFF_CTRL, 32'h7);
		fpull <= 4'h1;
		step(3);
		chk(32'({fe_off, crowbar, good_oe_n}), 32'h39, "propagated fault");
		chk(32'(good_out), 32'h0, "open-drain data low");
		@(posedge pclk);
		fpull <= 4'h0;
		step(3);
		chk(32'({fe_off, crowbar, good_oe_n}), 32'h0F, "fault recovered");
		$display("done propagation");
		// Group B off first so the trigger's auto turn-on is visible
		apb(1'b1, PGFS_OFF_INTCFG, 32'h2);
		apb(1'b1, PGFS_OFF_CMD, 32'h20);
		delay <= 8'($urandom_range(12, 40));
		int_n[1] <= 1'b0;
		step(6);
		chk(32'(prog_req), 32'h2, "trigger programs group B");
		wait_prog;
		chk(32'(good_oe_n), 32'hF, "group B auto on");
		@(posedge pclk);
		int_n[1] <= 1'b1;
		step(5);
		chk(32'(good_oe_n), 32'hD, "trigger release");
		apb(1'b0, PGFS_OFF_PROGSTAT, 32'h0);
		chk(rd, 32'h0, "status cleared");
		apb(1'b1, PGFS_OFF_INTCFG, 32'h0);
		apb(1'b1, PGFS_OFF_CMD, 32'h2);
		$display("done trigger");
		for (int k = 0; k < 2; k++) begin
			@(posedge pclk);
			if (k == 0) ml_n <= 1'b0;
			else sd_n <= 1'b0;
			step(5);
			chk(32'(good_oe_n), 32'h0, "all lines low");
			chk(rtc_cnt, k + 1, "counter saved");
			apb(1'b0, PGFS_OFF_STATUS, 32'h0);
			chk(32'(rd[17:16]), k == 0 ? 32'h1 : 32'h2, "input flagged");
			apb(1'b0, PGFS_OFF_PROGSTAT, 32'h0);
			chk(rd, 32'h0, "program status cleared");
			{ml_n, sd_n} <= 2'h3;
			step(6);
			chk(32'(prog_req), 32'hF, "reprogram all");
			wait_prog;
			chk(32'(good_oe_n), 32'hF, "auto on after return");
		end
		$display("done mains and shutdown");
		complete_run();
	end
endmodule
